/* File: pkg/ctb_pkg.sv */
package ctb_pkg;
	// Field bits are numbered from the MSB (bit 0) down to the LSB (bit 31)
	localparam int NBUF = 32;
	localparam logic [7:0] OFF_TX_BUFFER_CONFIG  = 8'hc0;
	localparam logic [7:0] OFF_FQS   = 8'hc4;
	localparam logic [7:0] OFF_ESC   = 8'hc8;
	localparam logic [7:0] OFF_PEND  = 8'hcc;
	localparam logic [7:0] OFF_ADD   = 8'hd0;
	localparam logic [7:0] OFF_CANC  = 8'hd4;
	localparam logic [7:0] OFF_SENT  = 8'hd8;
	localparam logic [7:0] OFF_CDONE = 8'hdc;
	localparam logic [7:0] OFF_CTRL  = 8'he8;
	localparam int QSEL_BIT  = 31 - 1;
	localparam int QSIZE_LSB = 31 - 7;
	localparam int DEDICATED_BUFFER_COUNT_LSB  = 31 - 15;
	localparam int BASE_LSB  = 31 - 29;
	localparam int FULL_BIT  = 31 - 10;
	localparam int PUT_LSB   = 31 - 15;
	localparam int GET_LSB   = 31 - 23;
	localparam int FREE_LSB  = 31 - 31;
	localparam int DSIZE_LSB = 31 - 31;
	localparam int UNLOCK_BIT = 0;
	localparam int NAR_BIT    = 1;
	localparam logic [31:0] TX_BUFFER_CONFIG_WMASK = 32'h7f3f_fffc;
	localparam logic [31:0] ESC_WMASK  = 32'h0000_0007;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0003;
	localparam logic [31:0] RST_TX_BUFFER_CONFIG = 32'h0000_0000;
	localparam logic [31:0] RST_ESC  = 32'h0000_0000;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [7:0]  PAD_BYTE = 8'hcc;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SCAN = 3'b010,
		ST_SEND = 3'b100
	} ctb_scan_e;

	function automatic logic [6:0] ctb_elem_bytes(input logic [2:0] code);
		case (code)
			3'h0: return 7'h08;
			3'h1: return 7'h0c;
			3'h2: return 7'h10;
			3'h3: return 7'h14;
			3'h4: return 7'h18;
			3'h5: return 7'h20;
			3'h6: return 7'h30;
			default: return 7'h40;
		endcase
	endfunction : ctb_elem_bytes
endpackage : ctb_pkg

/* File: pkg/ctb_core_if.sv */
`timescale 1ns/10ps
interface ctb_core_if;
	import ctb_pkg::*;
	logic            qsel;
	logic [5:0]      dedicated_buffer_count;
	logic [5:0]      qsize;
	logic [NBUF-1:0] pend;
	logic [4:0]      fput;
	logic            full;
	logic [4:0]      put;
	logic [4:0]      get;
	logic [5:0]      free;
	logic [2:0]      dsize;
	logic [5:0]      bidx;
	logic [7:0]      raw;
	logic [7:0]      pbyte;
	modport core(output qsel, dedicated_buffer_count, qsize, pend, fput, dsize, bidx, raw,
		input full, put, get, free, pbyte);
	modport stat(input qsel, dedicated_buffer_count, qsize, pend, fput, output full, put, get, free);
	modport pad(input dsize, bidx, raw, output pbyte);
endinterface : ctb_core_if

/* File: design/ctb_fq_status.sv */
`timescale 1ns/10ps
module ctb_fq_status (
	// Status view of the shared section
	ctb_core_if.stat cif
);
	import ctb_pkg::*;

	always_comb begin
		logic [6:0] p;
		logic [6:0] g;
		logic [5:0] fr;
		logic [4:0] qput;
		logic       stop;
		logic       found;
		p = 7'h00;
		g = 7'h00;
		fr = 6'h00;
		qput = 5'h00;
		stop = 1'b0;
		found = 1'b0;
		// Derived from the pending vector and the put pointer fput, so it lags a running scan [RQ6]
		for (int k = 0; k < NBUF; k++) begin
			if (6'(k) < cif.qsize && !stop) begin
				p = 7'(cif.fput) + 7'(k);
				if (p >= 7'(cif.qsize))
					p = p - 7'(cif.qsize);
				if (cif.pend[5'(p + 7'(cif.dedicated_buffer_count))])
					stop = 1'b1;
				else
					fr = fr + 6'h01;
			end
			if (6'(k) >= cif.dedicated_buffer_count && 7'(k) < 7'(cif.dedicated_buffer_count) + 7'(cif.qsize)
				&& !cif.pend[k] && !found) begin
				found = 1'b1;
				qput = 5'(k);
			end
		end
		g = 7'(cif.fput) + 7'(fr);
		if (g >= 7'(cif.qsize) && cif.qsize != 6'h00)
			g = g - 7'(cif.qsize);
		// Indices count from the first dedicated buffer [RQ7]
		if (cif.qsel) begin
			cif.full = !found; // [RQ8]
			cif.put  = qput;
			cif.get  = 5'h00; // [RQ9]
			cif.free = 6'h00; // [RQ10]
		end else begin
			cif.full = (fr == 6'h00); // [RQ8]
			cif.put  = 5'(cif.fput + 5'(cif.dedicated_buffer_count));
			cif.get  = 5'(g + 7'(cif.dedicated_buffer_count)); // [RQ9]
			cif.free = fr; // [RQ10]
		end
	end
endmodule : ctb_fq_status

/* File: design/ctb_pad.sv */
`timescale 1ns/10ps
module ctb_pad (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Byte lane
	ctb_core_if.pad  cif
);
	import ctb_pkg::*;

	typedef struct packed {
		logic [7:0] pbyte;
	} ctb_pad_s;

	ctb_pad_s st;
	ctb_pad_s next_st;

	always_comb begin
		next_st = st;
		// Bytes beyond the element size go out as padding [RQ12]
		if (7'(cif.bidx) < ctb_elem_bytes(cif.dsize))
			next_st.pbyte = cif.raw;
		else
			next_st.pbyte = PAD_BYTE;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign cif.pbyte = st.pbyte;

	property p_pad_fill;
		@(posedge aclk) disable iff (!aresetn)
		(7'(cif.bidx) >= ctb_elem_bytes(cif.dsize)) |=> (cif.pbyte == 8'hcc);
	endproperty
	a_pad_fill: assert property (p_pad_fill) else $error("padding byte wrong"); // [RQ12]
endmodule : ctb_pad

/* File: design/ctb_tx_request_ctrl.sv */
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
// Behaviour
// RQ1: Mode bit picks FIFO or queue, protected
// RQ2: Shared section size, capped at 32
// RQ3: Dedicated buffer count, capped at 32
// RQ4: Holds Tx section start word address
// RQ5: Software keeps both counts within 32
// RQ6: Status follows pending vector, may lag
// RQ7: Indices count from first dedicated buffer
// RQ8: Full flag and 5-bit put index
// RQ9: Get index, zero in queue mode
// RQ10: Free level, zero in queue mode
// RQ11: Element data size code, protected write
// RQ12: Missing data bytes sent as padding
// RQ13: Bits set mid-scan skipped; cancel clears
// RQ14: Pending set by add, configured buffers only
// RQ15: Pending starts scan; lowest identifier wins
// RQ16: Cancel of active send waits its end
// RQ17: Cancel finished in four cases
// RQ18: No retransmit cancels every failed send
// RQ19: Add to pending buffer is ignored
// RQ20: Add bits held only during scan
// RQ21: Cancel bit stays until pending clears
// RQ22: Sent flag set on success, cleared by add
// RQ23: Cancel-done set on cancel, cleared by add
// RQ24: All vectors reset to zero, one clock
module ctb_tx_request_ctrl (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Identifier lookup for the scan
	output logic [4:0]       id_idx,
	input  wire logic [28:0] id_val,
	// Protocol engine
	output logic             tx_start,
	output logic [4:0]       tx_buf,
	input  wire logic        tx_end,
	input  wire logic        tx_ok,
	output logic [13:0]      tx_base_word,
	// Data byte lane
	input  wire logic [5:0]  pad_idx,
	input  wire logic [7:0]  pad_raw,
	output logic [7:0]       pad_byte
);
	import ctb_pkg::*;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [31:0] tx_buffer_config;
		logic [31:0] esc;
		logic [31:0] ctrl;
		logic [31:0] pend;
		logic [31:0] add;
		logic [31:0] canc;
		logic [31:0] sent;
		logic [31:0] cdone;
		logic [31:0] cand;
		ctb_scan_e   fsm;
		logic [4:0]  idx;
		logic [4:0]  best;
		logic        best_v;
		logic [28:0] best_id;
		logic [4:0]  fput;
		logic        tx_start;
	} ctb_state_s;

	ctb_state_s s;
	ctb_state_s next_s;
	ctb_core_if cif ();

	function automatic logic [5:0] clip32(input logic [5:0] v);
		return (v > 6'd32) ? 6'd32 : v;
	endfunction : clip32

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] b);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (b[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction : merge

	logic [5:0]  dedicated_buffer_count_e;
	logic [5:0]  qsz_e;
	logic [6:0]  ncfg;
	logic [31:0] cfgm;
	logic [31:0] wbits;
	logic [31:0] fqs_word;
	logic        wr;
	logic        rd;

	// Counts beyond 32 behave as 32; an over-large sum is not flagged [RQ2] [RQ3] [RQ5]
	assign dedicated_buffer_count_e = clip32(s.tx_buffer_config[DEDICATED_BUFFER_COUNT_LSB +: 6]);
	assign ncfg   = 7'(dedicated_buffer_count_e) + 7'(clip32(s.tx_buffer_config[QSIZE_LSB +: 6]));
	assign qsz_e  = (ncfg > 7'd32) ? 6'(7'd32 - 7'(dedicated_buffer_count_e)) : 6'(ncfg - 7'(dedicated_buffer_count_e));
	assign cfgm   = (ncfg >= 7'd32) ? 32'hffff_ffff : ((32'h1 << ncfg) - 32'h1);
	assign wbits  = merge(32'h0, wdata, wstrb);
	assign wr = awvalid && wvalid && !s.awready && !s.bvalid;
	assign rd = arvalid && !s.arready && !s.rvalid;

	assign cif.qsel  = s.tx_buffer_config[QSEL_BIT]; // [RQ1]
	assign cif.dedicated_buffer_count  = dedicated_buffer_count_e;
	assign cif.qsize = qsz_e;
	assign cif.pend  = s.pend;
	assign cif.fput  = s.fput;
	assign cif.dsize = s.esc[DSIZE_LSB +: 3]; // [RQ11]
	assign cif.bidx  = pad_idx;
	assign cif.raw   = pad_raw;

	ctb_fq_status u_status (
		.cif (cif.stat)
	);

	ctb_pad u_pad (
		.aclk    (aclk),
		.aresetn (aresetn),
		.cif     (cif.pad)
	);

	always_comb begin
		fqs_word = 32'h0;
		fqs_word[FULL_BIT] = cif.full; // [RQ8]
		fqs_word[PUT_LSB +: 5] = cif.put;
		fqs_word[GET_LSB +: 5] = cif.get;
		fqs_word[FREE_LSB +: 6] = cif.free;
	end

	logic [31:0] addm;
	logic [31:0] newadd;
	logic [31:0] canm;
	logic [31:0] txm;
	logic [31:0] imm;
	logic [31:0] cnow;
	logic        bv;
	logic [4:0]  bb;
	logic [28:0] bid;
	logic        fin;
	logic [5:0]  putb;

	always_comb begin
		next_s = s;
		next_s.awready = 1'b0;
		next_s.wready = 1'b0;
		next_s.arready = 1'b0;
		next_s.tx_start = 1'b0;
		addm = 32'h0;
		canm = 32'h0;
		bv = s.best_v;
		bb = s.best;
		bid = s.best_id;
		fin = 1'b0;
		putb = 6'(dedicated_buffer_count_e + 6'(s.fput));
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		if (wr) begin
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (awaddr)
				OFF_TX_BUFFER_CONFIG: begin
					// Configuration only moves while unlocked [RQ1] [RQ4]
					if (s.ctrl[UNLOCK_BIT])
						next_s.tx_buffer_config = merge(s.tx_buffer_config, wdata, wstrb) & TX_BUFFER_CONFIG_WMASK;
				end
				OFF_ESC: begin
					if (s.ctrl[UNLOCK_BIT])
						next_s.esc = merge(s.esc, wdata, wstrb) & ESC_WMASK; // [RQ11]
				end
				OFF_CTRL: next_s.ctrl = merge(s.ctrl, wdata, wstrb) & CTRL_WMASK;
				OFF_ADD: addm = wbits & cfgm; // [RQ20]
				OFF_CANC: canm = wbits & cfgm; // [RQ21]
				OFF_FQS, OFF_PEND, OFF_SENT, OFF_CDONE: next_s.bresp = RESP_OKAY;
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		txm = (s.fsm == ST_SEND) ? (32'h1 << s.best) : 32'h0;
		newadd = addm & ~s.pend; // [RQ19]
		// Clears go first so a same-cycle set wins [RQ22] [RQ23]
		next_s.sent = s.sent & ~addm;
		next_s.cdone = s.cdone & ~addm;
		// Not on the wire: drop at once, even if set mid-scan [RQ13] [RQ17]
		imm = canm & ~txm;
		next_s.pend = (s.pend & ~imm) | newadd; // [RQ14]
		next_s.cdone = next_s.cdone | imm; // [RQ23]
		cnow = s.canc | (canm & txm);
		// Cancel bit falls the cycle after pending falls [RQ21] [RQ16]
		next_s.canc = cnow & s.pend;
		next_s.add = (s.fsm == ST_SCAN) ? (s.add | newadd) : 32'h0; // [RQ20]
		if (!cif.qsel && qsz_e != 6'h00 && putb < 6'd32 && newadd[5'(putb)])
			next_s.fput = (6'(s.fput) + 6'h01 == qsz_e) ? 5'h00 : s.fput + 5'h01;
		case (s.fsm)
			ST_IDLE: begin
				if (s.pend != 32'h0) begin
					// Snapshot: later additions wait for the next pass [RQ15] [RQ13]
					next_s.cand = s.pend;
					next_s.idx = 5'h00;
					next_s.best_v = 1'b0;
					next_s.fsm = ST_SCAN;
				end
			end
			ST_SCAN: begin
				if (s.cand[s.idx] && next_s.pend[s.idx] && (!bv || id_val < bid)) begin
					bv = 1'b1; // [RQ15]
					bb = s.idx;
					bid = id_val;
				end
				next_s.best_v = bv;
				next_s.best = bb;
				next_s.best_id = bid;
				next_s.idx = s.idx + 5'h01;
				if (s.idx == 5'd31) begin
					next_s.add = 32'h0; // [RQ20]
					if (bv && next_s.pend[bb]) begin
						next_s.tx_start = 1'b1;
						next_s.fsm = ST_SEND;
					end else begin
						next_s.fsm = ST_IDLE;
					end
				end
			end
			ST_SEND: begin
				if (tx_end) begin
					fin = tx_ok || s.ctrl[NAR_BIT] || cnow[s.best]; // [RQ16] [RQ18]
					if (fin)
						next_s.pend[s.best] = 1'b0;
					if (tx_ok)
						next_s.sent[s.best] = 1'b1; // [RQ22]
					if (cnow[s.best] || (!tx_ok && s.ctrl[NAR_BIT]))
						next_s.cdone[s.best] = 1'b1; // [RQ17] [RQ18]
					next_s.fsm = ST_IDLE;
				end
			end
			default: next_s.fsm = ST_IDLE;
		endcase
		if (rd) begin
			next_s.arready = 1'b1;
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			case (araddr)
				OFF_TX_BUFFER_CONFIG: next_s.rdata = s.tx_buffer_config;
				OFF_FQS: next_s.rdata = fqs_word;
				OFF_ESC: next_s.rdata = s.esc;
				OFF_PEND: next_s.rdata = s.pend;
				OFF_ADD: next_s.rdata = s.add;
				OFF_CANC: next_s.rdata = s.canc;
				OFF_SENT: next_s.rdata = s.sent;
				OFF_CDONE: next_s.rdata = s.cdone;
				OFF_CTRL: next_s.rdata = s.ctrl;
				default: begin
					next_s.rdata = 32'h0;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0; // [RQ24]
			s.tx_buffer_config <= RST_TX_BUFFER_CONFIG;
			s.esc <= RST_ESC;
			s.ctrl <= RST_CTRL;
			s.fsm <= ST_IDLE;
		end else begin
			s <= next_s; // [RQ24]
		end
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign id_idx = s.idx;
	assign tx_start = s.tx_start;
	assign tx_buf = s.best;
	assign tx_base_word = s.tx_buffer_config[BASE_LSB +: 14]; // [RQ4]
	assign pad_byte = cif.pbyte;

	logic [31:0] cd_req;
	assign cd_req = (wr && awaddr == OFF_CANC) ? (wbits & cfgm & ~s.pend) : 32'h0;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_locked;
		(wr && awaddr == OFF_TX_BUFFER_CONFIG && !s.ctrl[UNLOCK_BIT]) |=> $stable(s.tx_buffer_config);
	endproperty
	a_locked: assert property (p_locked) else $error("locked config changed"); // [RQ1]

	property p_add_cfg;
		(wr && awaddr == OFF_ADD) |=> ((s.pend & ~$past(s.pend) & ~$past(cfgm)) == 32'h0);
	endproperty
	a_add_cfg: assert property (p_add_cfg) else $error("unconfigured buffer pending"); // [RQ14]

	property p_add_scan;
		(s.add != 32'h0) |-> (s.fsm == ST_SCAN);
	endproperty
	a_add_scan: assert property (p_add_scan) else $error("add bits outside scan"); // [RQ20]

	property p_scan_len;
		(s.fsm == ST_SCAN && s.idx == 5'h00) |-> (s.fsm == ST_SCAN)[*8] ##25 (s.fsm != ST_SCAN);
	endproperty
	a_scan_len: assert property (p_scan_len) else $error("scan length wrong"); // [RQ15]

	property p_cancel_wait;
		(s.fsm == ST_SEND && s.canc[s.best] && !tx_end) |=> s.pend[$past(s.best)];
	endproperty
	a_cancel_wait: assert property (p_cancel_wait) else $error("active cancel early"); // [RQ16]

	property p_cdone_now;
		(cd_req != 32'h0) |=> ((s.cdone & $past(cd_req)) == $past(cd_req));
	endproperty
	a_cdone_now: assert property (p_cdone_now) else $error("cancel done missing"); // [RQ23]

	property p_nar_fail;
		(s.fsm == ST_SEND && tx_end && !tx_ok && s.ctrl[NAR_BIT])
		|=> !s.pend[$past(s.best)] && s.cdone[$past(s.best)];
	endproperty
	a_nar_fail: assert property (p_nar_fail) else $error("failed send not cancelled"); // [RQ18]

	property p_sent_ok;
		(s.fsm == ST_SEND && tx_end && tx_ok) |=> s.sent[$past(s.best)] && !s.pend[$past(s.best)];
	endproperty
	a_sent_ok: assert property (p_sent_ok) else $error("sent flag missing"); // [RQ22]

	property p_queue_get;
		s.tx_buffer_config[QSEL_BIT] |-> (fqs_word[GET_LSB +: 5] == 5'h00 && fqs_word[FREE_LSB +: 6] == 6'h00);
	endproperty
	a_queue_get: assert property (p_queue_get) else $error("queue get not zero"); // [RQ9]

	property p_bhold;
		(s.bvalid && !bready) |=> s.bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");

	c_start: cover property (s.fsm == ST_SCAN ##1 s.tx_start);
	c_cancel_tx: cover property (s.fsm == ST_SEND && s.canc[s.best] && tx_end);
	c_nar: cover property (s.fsm == ST_SEND && tx_end && !tx_ok && s.ctrl[NAR_BIT]);
endmodule : ctb_tx_request_ctrl

/* File: test/ctb_engine_model.sv */
`timescale 1ns/10ps
module ctb_engine_model (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Identifier lookup
	input  wire logic [4:0]  id_idx,
	output logic      [28:0] id_val,
	// Send handshake
	input  wire logic        tx_start,
	output logic             tx_end,
	output logic             tx_ok,
	// Bench knobs
	input  wire logic [9:0]  lat,
	input  wire logic        ok_cfg
);
	logic [9:0] cnt;
	logic       busy;

	// Higher buffer number carries the lower identifier
	assign id_val = {24'h0, ~id_idx};

	always @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			cnt <= '0;
			tx_end <= 1'b0;
			tx_ok <= ~ok_cfg;
		end else begin
			tx_end <= 1'b0;
			// Result line is only meaningful with the end pulse
			tx_ok <= ~ok_cfg;
			if (tx_start) begin
				busy <= 1'b1;
				cnt <= lat;
			end else if (busy && cnt == 0) begin
				busy <= 1'b0;
				tx_end <= 1'b1;
				tx_ok <= ok_cfg;
			end else if (busy) begin
				cnt <= cnt - 10'd1;
			end
		end
	end
endmodule : ctb_engine_model

/* File: test/ctb_tx_request_ctrl_tb.sv */
`timescale 1ns/10ps
module ctb_tx_request_ctrl_tb;
	import ctb_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ok_cfg;
	logic        awready, wready, bvalid, arready, rvalid, tx_start, tx_end, tx_ok;
	logic [7:0]  awaddr, araddr, pad_raw, pad_byte;
	logic [31:0] wdata, rdata, rd, cfg, m_pend, m_canc, m_sent, m_cdone;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic [4:0]  id_idx, tx_buf;
	logic [28:0] id_val;
	logic [13:0] tx_base_word, base;
	logic [5:0]  pad_idx;
	logic [9:0]  lat;
	logic [4:0]  started[$];
	int          err_count, checks_done, k;
	int          sz[8] = '{8, 12, 16, 20, 24, 32, 48, 64};
	logic [7:0]  regs[7] = '{OFF_TX_BUFFER_CONFIG, OFF_ESC, OFF_PEND, OFF_ADD, OFF_CANC, OFF_SENT, OFF_CDONE};

	ctb_tx_request_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .id_idx, .id_val, .tx_start, .tx_buf, .tx_end, .tx_ok,
		.tx_base_word, .pad_idx, .pad_raw, .pad_byte);
	ctb_engine_model eng (.aclk, .aresetn, .id_idx, .id_val, .tx_start, .tx_end, .tx_ok,
		.lat, .ok_cfg);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (tx_start === 1'b1) started.push_back(tx_buf);
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tmo(input int n);
		if (n >= 200) begin
			err_count++;
			$display("ERROR wait expected answer seen none");
			stop_test();
		end
	endtask : tmo

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic got;
		n = 0;
		got = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// Late bready lets the slave hold its response for a while
		do begin
			@(posedge aclk);
			n++;
			got = (bready === 1'b1 && bvalid === 1'b1);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (awvalid === 1'b0 && wvalid === 1'b0 && !got)
				bready <= 1'b1;
		end while (!got && n < 200);
		bready <= 1'b0;
		rs = bresp;
		tmo(n);
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		int   n;
		logic got;
		n = 0;
		got = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			got = (rvalid === 1'b1);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (!got && n < 200);
		rready <= 1'b0;
		rd = rdata;
		rs = rresp;
		tmo(n);
	endtask : rdr

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		rdr(a);
		chk(nm, rd, exp);
	endtask : rchk

	// Compare the pending, cancel, sent and cancel-done vectors with the bench model
	task automatic cmp_all;
		rchk("pending", OFF_PEND, m_pend);
		rchk("cancel", OFF_CANC, m_canc);
		rchk("sent", OFF_SENT, m_sent);
		rchk("cancel done", OFF_CDONE, m_cdone);
	endtask : cmp_all

	task automatic wait_pend(input logic [31:0] want);
		int n;
		n = 0;
		do begin
			rdr(OFF_PEND);
			n++;
		end while (rd !== want && n < 200);
		tmo(n);
	endtask : wait_pend

	task automatic wait_start(input int cnt);
		int n;
		n = 0;
		while (started.size() < cnt && n < 200) begin
			@(posedge aclk);
			n++;
		end
		tmo(n);
	endtask : wait_start

	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hf;
		pad_idx = '0;
		ok_cfg = 1'b1;
		lat = 10'd5;
		{m_pend, m_canc, m_sent, m_cdone} = '0;
		void'($urandom(32'h0fcf));
		base = 14'($urandom);
		pad_raw = 8'($urandom);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;

		foreach (regs[i]) rchk("reset value", regs[i], 32'h0);
		rchk("unmapped", 8'h00, 32'h0);
		chk("unmapped resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
		$display("test reset done");

		cfg = (32'h4 << QSIZE_LSB) | (32'h4 << DEDICATED_BUFFER_COUNT_LSB) | ({18'h0, base} << BASE_LSB);
		wr(OFF_TX_BUFFER_CONFIG, cfg);
		rchk("locked config", OFF_TX_BUFFER_CONFIG, 32'h0);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_TX_BUFFER_CONFIG, cfg);
		rchk("config", OFF_TX_BUFFER_CONFIG, cfg);
		chk("base word", {18'h0, tx_base_word}, {18'h0, base});
		rchk("fifo status", OFF_FQS, (32'h4 << PUT_LSB) | (32'h4 << GET_LSB) | 32'h4);
		$display("test config done");

		for (int c = 0; c < 8; c++) begin
			wr(OFF_ESC, 32'(c));
			rchk("elem size", OFF_ESC, 32'(c));
			pad_idx <= 6'(sz[c] - 1);
			repeat (2) @(posedge aclk);
			chk("raw byte", {24'h0, pad_byte}, {24'h0, pad_raw});
			if (sz[c] < 64) begin
				pad_idx <= 6'(sz[c]);
				repeat (2) @(posedge aclk);
				chk("pad byte", {24'h0, pad_byte}, 32'hcc);
			end
		end
		$display("test padding done");

		wr(OFF_ADD, 32'h8000_0000);
		cmp_all();
		wr(OFF_ADD, 32'h6);
		// Buffer 3 joins mid-scan; buffer 1 is already pending
		wr(OFF_ADD, 32'ha);
		rchk("add in scan", OFF_ADD, 32'h8);
		wait_pend(32'h0);
		m_sent = 32'he;
		cmp_all();
		chk("first sent", {27'h0, started[0]}, 32'd2);
		chk("second sent", {27'h0, started[1]}, 32'd3);
		chk("third sent", {27'h0, started[2]}, 32'd1);
		rchk("add idle", OFF_ADD, 32'h0);
		$display("test priority done");

		lat <= 10'd300;
		wr(OFF_ADD, 32'h2);
		{m_pend, m_sent} = {32'h2, 32'hc};
		cmp_all();
		wait_start(4);
		wr(OFF_ADD, 32'h1);
		wr(OFF_CANC, 32'h1);
		m_cdone = 32'h1;
		cmp_all();
		wr(OFF_CANC, 32'h2);
		m_canc = 32'h2;
		cmp_all();
		wait_pend(32'h0);
		{m_pend, m_canc, m_sent, m_cdone} = {32'h0, 32'h0, 32'he, 32'h3};
		cmp_all();
		wr(OFF_CANC, 32'h10);
		m_cdone = 32'h13;
		cmp_all();
		$display("test cancel done");

		wr(OFF_CTRL, 32'h3);
		{lat, ok_cfg} <= {10'd5, 1'b0};
		wr(OFF_ADD, 32'h8);
		m_sent = 32'h6;
		wait_pend(32'h0);
		m_cdone = 32'h1b;
		cmp_all();
		wr(OFF_CTRL, 32'h1);
		k = started.size();
		wr(OFF_ADD, 32'h8);
		m_cdone = 32'h13;
		wait_start(k + 2);
		rchk("retry pending", OFF_PEND, 32'h8);
		wr(OFF_CANC, 32'h8);
		wait_pend(32'h0);
		m_cdone = 32'h1b;
		cmp_all();
		$display("test retransmit done");

		wr(OFF_TX_BUFFER_CONFIG, cfg | (32'h1 << QSEL_BIT));
		rchk("queue status", OFF_FQS, 32'h4 << PUT_LSB);
		{lat, ok_cfg} <= {10'd300, 1'b1};
		k = started.size();
		wr(OFF_ADD, 32'hf0);
		wait_start(k + 1);
		rdr(OFF_FQS);
		chk("queue full", rd & ~(32'h1f << PUT_LSB), 32'h1 << FULL_BIT);
		chk("queue winner", {27'h0, started[k]}, 32'd7);
		wr(OFF_CANC, 32'hf0);
		wait_pend(32'h0);
		{m_sent, m_cdone} = {32'h86, 32'hfb};
		cmp_all();
		$display("test queue done");
		stop_test();
	end
endmodule : ctb_tx_request_ctrl_tb
